// [sacc_core.sv]
/*
 * Converter core control: acquisition and conversion sequencing, mux, reference.
 * Assumes the controller end supplies converter-clock ticks and legal settings.
 */
//
// Functional notes
// - Conversion takes resolution plus two ticks
// - Total time is acquisition plus conversion
// - Ten bit 12, eight bit 10 ticks
// - Twelve bit conversion phase is 14 ticks
// - Four global durations, 4 to 1023
// - After acquisition disconnect input, convert hold
// - Default 12 bit, one global alternate
// - Negative input: ground, reference or pin
// - Ground negative ignores signed, 0x000-0x7FF
// - Unsigned or signed mapping per negative
// - Three bit reference select codes 4-7
// - One bit enables bypass capacitor path
// - Controller limits converter clock per reference; divider is not checked, only 0 forced to 1
// - Converter clock by integer divider only
// - Controller waits for reference to settle
// - Mux from sequencer or firmware
// - Charge pump on below 4.0 V
`timescale 1ns/1ps
module sacc_core
    import sacc_pkg::*;
(
    input wire logic clk_i,           // System clock
    input wire logic rst_i,           // Synchronous reset, high
    sacc_if.core lnk,                 // Link to controller
    input wire logic [11:0] comp_i,   // Comparator decision code from analog array
    output logic sample_sw_o,         // Input connected to hold stage
    output logic [3:0] mux_sw_o,      // Mux switch pattern
    output logic [1:0] neg_sw_o,      // Negative input routing
    output logic [2:0] neg_pin_o,     // Negative pin index
    output logic [2:0] ref_mux_o,     // Reference mux select
    output logic bypass_o,            // Bypass capacitor switch
    output logic pump_o,              // Mux charge pump enable
    output logic [3:0] bit_o          // Bit under trial, one per tick
);
    typedef enum logic [2:0] {
        SACC_IDLE = 3'b001,
        SACC_ACQ = 3'b010,
        SACC_CONV = 3'b100
    } sacc_state_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pick one duration and clamp to the legal range
    function automatic logic [9:0] pick_acq(input logic [1:0] sel, input logic [31:0] a,
                                            input logic [31:0] b);
        logic [9:0] v;
        v = 10'h000;
        case (sel)
            2'h0: v = a[9:0];
            2'h1: v = a[25:16];
            2'h2: v = b[9:0];
            default: v = b[25:16];
        endcase
        if (v < SACC_ACQ_MIN) begin
            v = SACC_ACQ_MIN;
        end
        return v;
    endfunction

    sacc_state_t state;
    sacc_state_t next_state;
    logic [9:0] cnt;
    logic [9:0] next_cnt;
    logic [3:0] res;
    logic [1:0] neg;
    logic sgn;
    logic dif;
    logic [11:0] raw;
    logic [11:0] fmt;
    logic [11:0] result_q;
    logic eoc_q;

    // ------------------------------------------------------------
    // Setup decode
    // ------------------------------------------------------------
    wire [3:0] sel_res = lnk.alt_res ? (lnk.alt_is_10 ? SACC_RES_10 : SACC_RES_8)
                                     : SACC_RES_12;
    wire [9:0] sel_acq = pick_acq(lnk.acq_sel, lnk.acq_pair_a, lnk.acq_pair_b);
    wire [9:0] conv_len = {6'h00, res + SACC_CONV_EXTRA};
    wire tick = lnk.conv_tick;
    wire start_ok = lnk.start && (state == SACC_IDLE);

    // Next state; acquisition then conversion, each counted in ticks
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            SACC_IDLE: begin
                if (start_ok) begin
                    next_state = SACC_ACQ;
                    next_cnt = sel_acq;
                end
            end
            SACC_ACQ: begin
                if (tick) begin
                    next_cnt = cnt - 10'h001;
                    if (cnt == 10'h001) begin
                        next_state = SACC_CONV;
                        next_cnt = conv_len;
                    end
                end
            end
            SACC_CONV: begin
                if (tick) begin
                    next_cnt = cnt - 10'h001;
                    if (cnt == 10'h001) begin
                        next_state = SACC_IDLE;
                    end
                end
            end
            default: begin
                next_state = SACC_IDLE;
                next_cnt = 10'h000;
            end
        endcase
    end

    // Result coding; ground negative is 11-bit so signed flag is moot
    wire [11:0] raw12 = raw << (SACC_RES_12 - res);
    wire force_uns = !dif && (neg == SACC_NEG_GND);
    wire [11:0] gnd_fmt = {1'b0, raw12[10:0]};
    wire [11:0] dif_fmt = sgn ? {~raw12[11], raw12[10:0]} : raw12;
    wire [11:0] code_out = force_uns ? gnd_fmt : dif_fmt;
    wire [3:0] bit_idx = (cnt > 10'h002) ? cnt[3:0] - 4'h3 : 4'h0;

    // ------------------------------------------------------------
    // Sequencing registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SACC_IDLE;
            cnt <= 10'h000;
            res <= SACC_RES_12;
            neg <= SACC_NEG_GND;
            sgn <= 1'b0;
            dif <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            if (start_ok) begin
                res <= sel_res;
                neg <= lnk.neg_sel;
                sgn <= lnk.signed_fmt;
                dif <= lnk.diff;
            end
        end
    end

    // Capture held code; low bits beyond resolution dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw <= 12'h000;
            result_q <= 12'h000;
            eoc_q <= 1'b0;
        end else begin
            eoc_q <= 1'b0;
            if (state == SACC_CONV && tick && cnt == 10'h003) begin
                raw <= comp_i >> (SACC_RES_12 - res);
            end
            if (state == SACC_CONV && tick && cnt == 10'h001) begin
                result_q <= code_out;
                eoc_q <= 1'b1;
            end
        end
    end

    // Analog switch registers; the switch opens on leaving acquisition
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_sw_o <= 1'b0;
            mux_sw_o <= 4'h0;
            neg_sw_o <= SACC_NEG_GND;
            neg_pin_o <= 3'h0;
            ref_mux_o <= SACC_CTRL_RST[6:4];
            bypass_o <= 1'b0;
            pump_o <= 1'b0;
            bit_o <= 4'h0;
        end else begin
            sample_sw_o <= (next_state == SACC_ACQ);
            mux_sw_o <= lnk.mux_fw ? lnk.mux_fw_sw : {2'b00, lnk.acq_sel};
            neg_sw_o <= lnk.diff ? SACC_NEG_PIN : lnk.neg_sel;
            neg_pin_o <= lnk.neg_pin;
            ref_mux_o <= lnk.ref_sel;
            bypass_o <= lnk.bypass_en;
            pump_o <= lnk.pump_en;
            bit_o <= (state == SACC_CONV) ? bit_idx : 4'h0;
        end
    end

    assign lnk.busy = (state != SACC_IDLE);
    assign lnk.eoc = eoc_q;
    assign lnk.result = result_q;
endmodule

// [sacc_pkg.sv]
/*
 * Shared constants for the converter core control block and its controller end.
 * Assumes a single 40 MHz clock domain on both ends.
 */
package sacc_pkg;
    // ------------------------------------------------------------
    // Converter timing
    // ------------------------------------------------------------
    localparam int unsigned SACC_CLK_HZ = 40000000;
    localparam logic [9:0] SACC_ACQ_MIN = 10'h004;
    localparam logic [9:0] SACC_ACQ_MAX = 10'h3FF;
    localparam logic [3:0] SACC_CONV_EXTRA = 4'h2;
    localparam logic [3:0] SACC_RES_12 = 4'hC;
    localparam logic [3:0] SACC_RES_10 = 4'hA;
    localparam logic [3:0] SACC_RES_8 = 4'h8;
    // Converter clock divider reset value (40 MHz / 5 = 8 MHz); stays under the
    // supply-reference limit, since the reference resets to the supply
    localparam logic [7:0] SACC_DIV_RST = 8'h05;
    // Reference settle wait, 200 us at 40 MHz
    localparam int unsigned SACC_SETTLE_US = 200;
    localparam int unsigned SACC_SETTLE_CYC = SACC_SETTLE_US * (SACC_CLK_HZ / 1000000);
    // ------------------------------------------------------------
    // Negative input choice
    // ------------------------------------------------------------
    localparam logic [1:0] SACC_NEG_GND = 2'h0;
    localparam logic [1:0] SACC_NEG_REF = 2'h1;
    localparam logic [1:0] SACC_NEG_PIN = 2'h2;
    // ------------------------------------------------------------
    // Reference select field codes, global control layout
    // ------------------------------------------------------------
    localparam logic [2:0] SACC_REF_BANDGAP = 3'h4;
    localparam logic [2:0] SACC_REF_EXT = 3'h5;
    localparam logic [2:0] SACC_REF_HALF_VDDA = 3'h6;
    localparam logic [2:0] SACC_REF_VDDA = 3'h7;
    localparam int unsigned SACC_CTRL_REF_LSB = 4;
    localparam int unsigned SACC_CTRL_BYP_BIT = 7;
    localparam logic [7:0] SACC_CTRL_RST = 8'h70;
    // ------------------------------------------------------------
    // Controller register map (Wishbone byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] SACC_REG_CTRL = 5'h00;
    localparam logic [4:0] SACC_REG_ACQ_A = 5'h04;
    localparam logic [4:0] SACC_REG_ACQ_B = 5'h08;
    localparam logic [4:0] SACC_REG_CHAN = 5'h0C;
    localparam logic [4:0] SACC_REG_START = 5'h10;
    localparam logic [4:0] SACC_REG_STATUS = 5'h14;
    localparam logic [4:0] SACC_REG_RESULT = 5'h18;
    localparam logic [31:0] SACC_ACQ_RST = 32'h00040004;
endpackage

// [sacc_if.sv]
/*
 * Link between the converter core control and its controlling party.
 * Both ends on clk_i; no clocking block, the bench joins the ends here.
 */
`timescale 1ns/1ps
interface sacc_if;
    logic conv_tick;          // Converter-clock enable pulse
    logic start;              // Start one sample
    logic [1:0] acq_sel;      // Which of four durations
    logic alt_res;            // Use alternate resolution
    logic [1:0] neg_sel;      // Negative input choice
    logic [2:0] neg_pin;      // Negative pin index
    logic diff;               // Differential mode
    logic signed_fmt;         // Signed result
    logic alt_is_10;          // Alternate resolution is 10 bit
    logic [31:0] acq_pair_a;  // Durations 0 and 1
    logic [31:0] acq_pair_b;  // Durations 2 and 3
    logic [2:0] ref_sel;      // Reference select
    logic bypass_en;          // Bypass capacitor path
    logic mux_fw;             // Mux under firmware control
    logic [3:0] mux_fw_sw;    // Firmware mux switch pattern
    logic pump_en;            // Mux charge pump enable
    logic busy;               // Core busy
    logic eoc;                // End of conversion pulse
    logic [11:0] result;      // Result word
    modport core (input conv_tick, start, acq_sel, alt_res, neg_sel, neg_pin, diff, signed_fmt,
                  alt_is_10, acq_pair_a, acq_pair_b, ref_sel, bypass_en, mux_fw, mux_fw_sw,
                  pump_en, output busy, eoc, result);
    modport ctl (output conv_tick, start, acq_sel, alt_res, neg_sel, neg_pin, diff, signed_fmt,
                 alt_is_10, acq_pair_a, acq_pair_b, ref_sel, bypass_en, mux_fw, mux_fw_sw,
                 pump_en, input busy, eoc, result);
endinterface

// [sacc_ctl.sv]
/*
 * Controller end: Wishbone slave registers, converter clock divider, settle wait.
 * Assumes a classic Wishbone master on clk_i and the core end on the link.
 */
`timescale 1ns/1ps
module sacc_ctl
    import sacc_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = SACC_SETTLE_CYC // Reference settle wait in clocks
) (
    input wire logic clk_i,          // System clock
    input wire logic rst_i,          // Synchronous reset, high
    input wire logic wb_cyc_i,       // Wishbone cycle
    input wire logic wb_stb_i,       // Wishbone strobe
    input wire logic wb_we_i,        // Wishbone write
    input wire logic [4:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte enables
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o,    // Wishbone read data
    output logic wb_ack_o,           // Wishbone acknowledge
    sacc_if.ctl lnk                  // Link to core
);
    logic [7:0] ctrl;
    logic [31:0] acq_a;
    logic [31:0] acq_b;
    logic [15:0] chan;
    logic [7:0] div;
    logic [7:0] div_cnt;
    logic [19:0] settle;
    logic start_q;
    logic done;
    logic [11:0] res_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i;
    wire wr_ctrl = wr && wb_adr_i == SACC_REG_CTRL;
    wire wr_start = wr && wb_adr_i == SACC_REG_START && wb_sel_i[0] && wb_dat_i[0];
    wire settled = (settle == 20'h00000);
    wire [31:0] ctrl_w = merge({8'h00, div, 8'h00, ctrl}, wb_dat_i, wb_sel_i);
    wire [2:0] new_ref = ctrl_w[SACC_CTRL_REF_LSB +: 3];
    wire [31:0] chan_w = merge({16'h0000, chan}, wb_dat_i, wb_sel_i);

    // Registers; a settle wait restarts on any reference change
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= SACC_CTRL_RST;
            div <= SACC_DIV_RST;
            acq_a <= SACC_ACQ_RST;
            acq_b <= SACC_ACQ_RST;
            chan <= 16'h0000;
            settle <= SETTLE_CYC[19:0];
        end else begin
            if (wr_ctrl) begin
                ctrl <= ctrl_w[7:0];
                div <= (ctrl_w[23:16] == 8'h00) ? 8'h01 : ctrl_w[23:16];
                if (new_ref != ctrl[6:4]) begin
                    settle <= SETTLE_CYC[19:0];
                end
            end else if (!settled) begin
                settle <= settle - 20'h00001;
            end
            if (wr && wb_adr_i == SACC_REG_ACQ_A) acq_a <= merge(acq_a, wb_dat_i, wb_sel_i);
            if (wr && wb_adr_i == SACC_REG_ACQ_B) acq_b <= merge(acq_b, wb_dat_i, wb_sel_i);
            if (wr && wb_adr_i == SACC_REG_CHAN) chan <= chan_w[15:0];
        end
    end

    // Start held until core is busy, so one written mid-sample is lost; done set wins over read clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
            done <= 1'b0;
            res_q <= 12'h000;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (wr_start && settled) start_q <= 1'b1;
            else if (lnk.busy) start_q <= 1'b0;
            if (lnk.eoc) begin
                done <= 1'b1;
                res_q <= lnk.result;
            end else if (req && !wb_we_i && wb_adr_i == SACC_REG_RESULT) begin
                done <= 1'b0;
            end
            case (wb_adr_i)
                SACC_REG_CTRL: wb_dat_o <= {8'h00, div, 8'h00, ctrl};
                SACC_REG_ACQ_A: wb_dat_o <= acq_a;
                SACC_REG_ACQ_B: wb_dat_o <= acq_b;
                SACC_REG_CHAN: wb_dat_o <= {16'h0000, chan};
                SACC_REG_STATUS: wb_dat_o <= {29'h0, settled, done, lnk.busy};
                SACC_REG_RESULT: wb_dat_o <= {20'h0, res_q};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Integer divider for converter ticks; compare is >= so a divider lowered
    // mid-count wraps at once instead of running through all 256 counts
    always_ff @(posedge clk_i) begin
        if (rst_i || div_cnt >= div - 8'h01) div_cnt <= 8'h00;
        else div_cnt <= div_cnt + 8'h01;
    end

    assign lnk.conv_tick = (div_cnt >= div - 8'h01);
    assign lnk.start = start_q && !lnk.busy;
    assign lnk.acq_sel = chan[1:0];
    assign lnk.alt_res = chan[2];
    assign lnk.neg_sel = chan[4:3];
    assign lnk.neg_pin = chan[7:5];
    assign lnk.diff = chan[8];
    assign lnk.signed_fmt = chan[9];
    assign lnk.alt_is_10 = chan[10];
    assign lnk.mux_fw = chan[11];
    assign lnk.mux_fw_sw = chan[15:12];
    assign lnk.acq_pair_a = acq_a;
    assign lnk.acq_pair_b = acq_b;
    assign lnk.ref_sel = ctrl[6:4];
    assign lnk.bypass_en = ctrl[SACC_CTRL_BYP_BIT];
    assign lnk.pump_en = ctrl[0];
endmodule

// [sacc_chk.sv]
/*
 * Checker for the link between converter control and core.
 * Assumes one clock domain; instantiated beside the interface by the bench.
 */
`timescale 1ns/1ps
module sacc_chk
    import sacc_pkg::*;
(
    input logic clk_i,             // System clock
    input logic rst_i,             // Synchronous reset
    input logic conv_tick,         // Converter tick
    input logic start,             // Start request
    input logic [1:0] acq_sel,     // Duration choice
    input logic alt_res,           // Alternate resolution
    input logic alt_is_10,         // Alternate is 10 bit
    input logic [1:0] neg_sel,     // Negative input choice
    input logic diff,              // Differential mode
    input logic [31:0] acq_pair_a, // Durations 0 and 1
    input logic [31:0] acq_pair_b, // Durations 2 and 3
    input logic busy,              // Core busy
    input logic eoc,               // End of conversion
    input logic [11:0] result      // Result word
);
    // ------------------------------------------------------------
    // Expected tick span, latched when a start is taken
    // ------------------------------------------------------------
    logic [10:0] tick_cnt;
    logic [10:0] exp_ticks;
    wire [31:0] pair_w = acq_sel[1] ? acq_pair_b : acq_pair_a;
    wire [9:0] acq_w = acq_sel[0] ? pair_w[25:16] : pair_w[9:0];
    wire [9:0] acq_c = (acq_w < SACC_ACQ_MIN) ? SACC_ACQ_MIN : acq_w;
    wire [3:0] res_w = !alt_res ? SACC_RES_12 : (alt_is_10 ? SACC_RES_10 : SACC_RES_8);

    // Ticks counted only while busy, so idle ticks cannot pad the span
    always_ff @(posedge clk_i) begin
        if (rst_i || (start && !busy)) begin
            tick_cnt <= '0;
            exp_ticks <= {1'b0, acq_c} + 11'(res_w) + 11'(SACC_CONV_EXTRA);
        end else if (busy && conv_tick) begin
            tick_cnt <= tick_cnt + 11'h001;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    tick_count_a: assert property (eoc |-> tick_cnt == exp_ticks)
        else $error("conversion tick count wrong");
    eoc_pulse_a: assert property (eoc |=> !eoc)
        else $error("end pulse longer than one cycle");
    result_hold_a: assert property (!eoc |-> $stable(result))
        else $error("result changed without end pulse");
    gnd_range_a: assert property (eoc && neg_sel == SACC_NEG_GND && !diff |-> !result[11])
        else $error("ground-referred result above 0x7FF");
    start_busy_a: assert property (start && !busy |=> busy)
        else $error("start not taken");
    eoc_busy_a: assert property (eoc |-> $past(busy))
        else $error("end pulse while idle");
    min_len_a: assert property ($rose(busy) |-> !eoc [*8])
        else $error("conversion ended too early");
    eoc_bound_a: assert property (start && !busy |=> ##[1:1000] eoc)
        else $error("conversion never ended");
endmodule

// [sar_adc_core_control_tb_top.sv]
/*
 * Self-checking bench: Wishbone master on the controller, comparator code on the core.
 * Assumes both ends share clk_i; results are queued by the driver and checked on eoc.
 */
`timescale 1ns/1ps
module sar_adc_core_control_tb_top;
    import sacc_pkg::*;
    localparam int unsigned SETTLE = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [11:0] comp_i = '0;
    logic sample_sw_o, bypass_o, pump_o;
    logic [3:0] mux_sw_o, bit_o;
    logic [1:0] neg_sw_o;
    logic [2:0] neg_pin_o, ref_mux_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int done_cnt = 0;
    int samp_cnt = 0;
    logic [11:0] exp_q[$];
    logic [11:0] e_m;

    initial forever #12.5 clk_i = ~clk_i;

    sacc_if u_sacc_if();
    sacc_core u_sacc_core(.clk_i(clk_i), .rst_i(rst_i), .lnk(u_sacc_if), .comp_i(comp_i),
        .sample_sw_o(sample_sw_o), .mux_sw_o(mux_sw_o), .neg_sw_o(neg_sw_o), .neg_pin_o(neg_pin_o),
        .ref_mux_o(ref_mux_o), .bypass_o(bypass_o), .pump_o(pump_o), .bit_o(bit_o));
    sacc_ctl #(.SETTLE_CYC(SETTLE)) u_sacc_ctl(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lnk(u_sacc_if));
    sacc_chk u_sacc_chk(.clk_i(clk_i), .rst_i(rst_i), .conv_tick(u_sacc_if.conv_tick),
        .start(u_sacc_if.start), .acq_sel(u_sacc_if.acq_sel), .alt_res(u_sacc_if.alt_res),
        .alt_is_10(u_sacc_if.alt_is_10), .neg_sel(u_sacc_if.neg_sel), .diff(u_sacc_if.diff),
        .acq_pair_a(u_sacc_if.acq_pair_a), .acq_pair_b(u_sacc_if.acq_pair_b),
        .busy(u_sacc_if.busy), .eoc(u_sacc_if.eoc), .result(u_sacc_if.result));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle; held until ack, then one idle cycle
    task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    task automatic wait_settled();
        logic [31:0] v;
        int n;
        v = '0;
        for (n = 0; v[2] !== 1'b1; n++) begin
            if (n > 40) begin
                error_cnt++;
                end_of_test();
            end
            wb(1'b0, SACC_REG_STATUS, 32'h0, v);
        end
    endtask

    // ------------------------------------------------------------
    // Result monitor: oldest note against each end pulse
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (sample_sw_o === 1'b1) samp_cnt++;
        if (u_sacc_if.eoc === 1'b1) begin
            e_m = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            check({20'h0, u_sacc_if.result}, {20'h0, e_m});
            check({31'h0, sample_sw_o}, 32'h0);
            check({28'h0, bit_o}, 32'h0);
            done_cnt++;
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v, chan;
        logic [11:0] c, e;
        logic [3:0] res;
        int acq[4];
        int div, i, n, d0;
        void'($urandom(33814));
        div = 4;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({29'h0, ref_mux_o}, 32'h7);
        check({30'h0, bypass_o, pump_o}, 32'h0);
        wb(1'b1, SACC_REG_START, 32'h1, v);
        wb(1'b0, SACC_REG_STATUS, 32'h0, v);
        check({31'h0, v[0]}, 32'h0);
        wb(1'b0, SACC_REG_CTRL, 32'h0, v);
        check(v, {8'h00, SACC_DIV_RST, 8'h00, SACC_CTRL_RST});
        wb(1'b0, SACC_REG_ACQ_A, 32'h0, v);
        check(v, SACC_ACQ_RST);
        wb(1'b1, 5'h1C, 32'hFFFFFFFF, v);
        wb(1'b0, 5'h1C, 32'h0, v);
        check(v, 32'h0);
        wait_settled();
        // Each reference code; a start during the new settle is refused
        for (i = 4; i < 8; i++) begin
            // Converter clock kept legal: 1.6 MHz buffered without bypass, 5 to 8 MHz with bypass
            div = (i == 4 || i == 6) ? 25 : $urandom_range(5, 8);
            wb(1'b1, SACC_REG_CTRL, {8'h0, 8'(div), 8'h0, i[0], i[2:0], 3'h0, i[1]}, v);
            wb(1'b1, SACC_REG_START, 32'h1, v);
            wb(1'b0, SACC_REG_STATUS, 32'h0, v);
            check({31'h0, v[0]}, 32'h0);
            check({29'h0, ref_mux_o}, i);
            check({30'h0, bypass_o, pump_o}, {30'h0, i[0], i[1]});
            wait_settled();
        end
        // Durations; the last one is written below the floor and must act as 4
        for (i = 0; i < 3; i++) acq[i] = $urandom_range(4, 40);
        acq[3] = 4;
        wb(1'b1, SACC_REG_ACQ_A, {6'h0, 10'(acq[1]), 6'h0, 10'(acq[0])}, v);
        wb(1'b1, SACC_REG_ACQ_B, {6'h0, 10'h001, 6'h0, 10'(acq[2])}, v);
        for (i = 0; i < 24; i++) begin
            chan = {16'h0, 4'($urandom), 1'($urandom), i[3], i[4] ^ 1'($urandom), 1'($urandom),
                    3'($urandom), 2'(i % 3), i[2], i[1:0]};
            res = !chan[2] ? SACC_RES_12 : (chan[10] ? SACC_RES_10 : SACC_RES_8);
            c = 12'($urandom);
            comp_i <= c;
            // Core keeps the top res bits of the held code on the 12-bit scale
            e = 12'((c >> (12 - res)) << (12 - res));
            if (chan[4:3] == SACC_NEG_GND && !chan[8]) e[11] = 1'b0;
            else if (chan[9]) e[11] = ~e[11];
            wb(1'b1, SACC_REG_CHAN, chan, v);
            exp_q.push_back(e);
            samp_cnt = 0;
            d0 = done_cnt;
            wb(1'b1, SACC_REG_START, 32'h1, v);
            for (n = 0; done_cnt == d0; n++) begin
                if (n > 2000) begin
                    error_cnt++;
                    end_of_test();
                end
                @(posedge clk_i);
            end
            n = acq[chan[1:0]];
            check(32'(samp_cnt >= (n - 1) * div && samp_cnt <= (n + 1) * div), 32'h1);
            check({27'h0, neg_sw_o, neg_pin_o}, {27'h0, (chan[8] ? SACC_NEG_PIN : chan[4:3]), chan[7:5]});
            if (chan[11]) check({28'h0, mux_sw_o}, {28'h0, chan[15:12]});
            wb(1'b0, SACC_REG_RESULT, 32'h0, v);
            check({20'h0, v[11:0]}, {20'h0, e});
            wb(1'b0, SACC_REG_STATUS, 32'h0, v);
            check({30'h0, v[1:0]}, 32'h0);
        end
        end_of_test();
    end
endmodule
